//--- rtl/asf_pkg.sv
// Constants for the conversion status flag logic and its serial command port
package asf_pkg;
    localparam int          CMD_BITS        = 8;
    localparam int          ADDR_WIDTH      = 6;
    localparam int          STATUS_WIDTH    = 8;
    localparam int          RESULT_WIDTH    = 24;
    localparam int          CHANNEL_WIDTH   = 4;
    localparam int          SHIFT_WIDTH     = 32;
    localparam int          COUNT_WIDTH     = 6;
    localparam int          SYNC_STAGES     = 2;
    // Command byte fields
    localparam int          CMD_WEN_BIT     = 7;
    localparam int          CMD_RW_BIT      = 6;
    localparam int          CMD_ADDR_MSB    = 5;
    // Register addresses
    localparam logic [5:0]  ADDR_STATUS     = 6'h00;
    localparam logic [5:0]  ADDR_DATA       = 6'h04;
    // Status field positions and reset value
    localparam int          RDY_BIT         = 7;
    localparam int          RANGE_ERR_BIT   = 6;
    localparam int          CRC_ERR_BIT     = 5;
    localparam int          INTEG_ERR_BIT   = 4;
    localparam int          CHAN_MSB        = 3;
    localparam logic [7:0]  STATUS_RESET    = 8'h80;
    // Clamp values
    localparam logic [23:0] RESULT_OVER     = 24'hFFFFFF;
    localparam logic [23:0] RESULT_UNDER    = 24'h000000;
    // Transfer lengths in bits
    localparam logic [5:0]  LEN_STATUS      = 6'h08;
    localparam logic [5:0]  LEN_DATA        = 6'h18;
    localparam logic [5:0]  LEN_DATA_STAT   = 6'h20;
    localparam logic [5:0]  LEN_OTHER       = 6'h08;

    typedef enum logic [1:0] {
        ASF_CMD   = 2'b00,
        ASF_READ  = 2'b01,
        ASF_WRITE = 2'b10
    } asf_state_type;
endpackage

//--- rtl/asf_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module asf_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] reset_value,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    // Reset value held constant by the caller; loaded after release only
    logic             started;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stage1  <= '0;
            stage2  <= '0;
            started <= 1'b0;
        end else begin
            started <= 1'b1;
            stage1  <= async_in;
            stage2  <= started ? stage1 : reset_value;
        end
    end

    // Idle level until the first edge, so no false select or edge follows reset
    assign sync_out = started ? stage2 : reset_value;
endmodule
`default_nettype wire

//--- rtl/asf_status_flags.sv
// Conversion status register with its serial command port
// Function
// R1: Status register is 8 bits at address 0x00, reset 0x80.
// R2: With append enabled, status byte follows data on every data read.
// R3: Chip select low and no read: ready flag drives serial-out pin.
// R4: Ready flag goes low when a new result is written.
// R5: In calibration modes ready goes low on calibration result write instead.
// R6: Any data register read sets ready back to one.
// R7: Range error flag on over/underrange; result clamped to ones or zeros.
// R8: Range flag updates only on result write; clears once condition gone.
// R9: Checksum error flag set by register write with failing check.
// R10: Reading status register clears checksum error flag.
// R11: Integrity flag set on register content mismatch while check enabled.
// R12: Integrity flag cleared only by clearing the check enable.
// R13: Bits 3:0 hold channel of result in data register.
// R14: Host reads status by command byte 0x40 first.
// R15: Status register is read-only; writes change nothing.
`timescale 1ns/1ps
`default_nettype none
module asf_status_flags #(
    parameter int RESULT_WIDTH  = asf_pkg::RESULT_WIDTH,
    parameter int CHANNEL_WIDTH = asf_pkg::CHANNEL_WIDTH
) (
    input  wire logic                     sys_clk,
    input  wire logic                     rstn,
    // Serial pins
    input  wire logic                     csN,
    input  wire logic                     sclk,
    input  wire logic                     din,
    output logic                          doutRdy,
    output logic                          doutRdyOe,
    // Conversion side
    input  wire logic                     resultWrite,
    input  wire logic [RESULT_WIDTH-1:0]  resultValue,
    input  wire logic [CHANNEL_WIDTH-1:0] resultChannel,
    input  wire logic                     overRange,
    input  wire logic                     underRange,
    input  wire logic                     calibMode,
    input  wire logic                     calibWrite,
    // Interface mode bits and integrity engine
    input  wire logic                     appendStatus,
    input  wire logic                     integrityEnable,
    input  wire logic                     integrityMismatch,
    input  wire logic                     writeCrcFail,
    // Observation
    output logic [7:0]                    conversionStatus,
    output logic [RESULT_WIDTH-1:0]       dataValue,
    output logic [5:0]                    targetRegisterSelect,
    output logic                          writeByteValid,
    output logic [7:0]                    writeByte
);
    // Pins synchronised; chip select rests high
    logic [2:0] pinSync;

    asf_sync #(
        .WIDTH(3)
    ) u_sync (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .async_in   ({csN, sclk, din}),
        .reset_value(3'b110),
        .sync_out   (pinSync)
    );

    wire logic csSync   = pinSync[2];
    wire logic sclkSync = pinSync[1];
    wire logic dinSync  = pinSync[0];

    logic sclkPrev;
    wire logic sclkRise = sclkSync && !sclkPrev && !csSync;
    wire logic sclkFall = !sclkSync && sclkPrev && !csSync;

    asf_pkg::asf_state_type state;
    asf_pkg::asf_state_type next_state;

    logic [5:0]  bitCount;
    logic [5:0]  xferLen;
    logic [31:0] shifter;
    logic [7:0]  cmdShift;
    logic        readIsStatus;

    // Status fields
    logic                     rdyFlag;
    logic                     rangeErr;
    logic                     crcErr;
    logic                     integErr;
    logic [CHANNEL_WIDTH-1:0] chanTag;
    logic [RESULT_WIDTH-1:0]  dataReg;

    assign conversionStatus = {rdyFlag, rangeErr, crcErr, integErr, chanTag}; // see R1 see R13

    // Command decode
    wire logic [7:0] cmdByte   = {cmdShift[6:0], dinSync};
    wire logic       cmdDone   = (state == asf_pkg::ASF_CMD) && sclkRise
                                 && (bitCount == asf_pkg::LEN_STATUS - 6'h01);
    wire logic       cmdValid  = cmdDone && !cmdByte[asf_pkg::CMD_WEN_BIT];
    wire logic       cmdRead   = cmdValid && cmdByte[asf_pkg::CMD_RW_BIT];
    wire logic       cmdWrite  = cmdValid && !cmdByte[asf_pkg::CMD_RW_BIT];
    wire logic [5:0] cmdAddr   = cmdByte[asf_pkg::CMD_ADDR_MSB:0];
    wire logic       addrStat  = (cmdAddr == asf_pkg::ADDR_STATUS);
    wire logic       addrData  = (cmdAddr == asf_pkg::ADDR_DATA);

    wire logic       dataRead  = cmdRead && addrData;
    wire logic       lastBit   = sclkRise && (bitCount == xferLen - 6'h01);
    wire logic       readEnd   = (state == asf_pkg::ASF_READ) && lastBit;
    wire logic       writeEnd  = (state == asf_pkg::ASF_WRITE) && lastBit;
    wire logic       statusRdEnd = readEnd && readIsStatus;

    // Read load selection
    wire logic [5:0]  loadLen  = addrStat ? asf_pkg::LEN_STATUS
                               : addrData ? (appendStatus ? asf_pkg::LEN_DATA_STAT : asf_pkg::LEN_DATA) // see R2
                               : asf_pkg::LEN_OTHER;
    wire logic [31:0] loadWord = addrStat ? {conversionStatus, 24'h000000}
                               : addrData ? {dataReg, conversionStatus}
                               : 32'h00000000;

    // Result events
    wire logic rdyClear  = calibMode ? calibWrite : resultWrite; // see R4 see R5
    wire logic convWrite = resultWrite && !calibMode;

    wire logic [RESULT_WIDTH-1:0] clampedResult = overRange  ? asf_pkg::RESULT_OVER
                                                : underRange ? asf_pkg::RESULT_UNDER
                                                : resultValue; // see R7

    always_comb begin
        next_state = state;
        case (state)
            asf_pkg::ASF_CMD: begin
                if (cmdRead) begin
                    next_state = asf_pkg::ASF_READ;
                end else if (cmdWrite) begin
                    next_state = asf_pkg::ASF_WRITE;
                end
            end
            asf_pkg::ASF_READ: begin
                if (lastBit) begin
                    next_state = asf_pkg::ASF_CMD;
                end
            end
            asf_pkg::ASF_WRITE: begin
                if (lastBit) begin
                    next_state = asf_pkg::ASF_CMD;
                end
            end
            default: begin
                next_state = asf_pkg::ASF_CMD;
            end
        endcase
        if (csSync) begin
            next_state = asf_pkg::ASF_CMD;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state    <= asf_pkg::ASF_CMD;
            sclkPrev <= 1'b1;
        end else begin
            state    <= next_state;
            sclkPrev <= sclkSync;
        end
    end

    // Bit counter restarts on every phase change and on deselect
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bitCount <= 6'h00;
        end else if (csSync || cmdDone || lastBit) begin
            bitCount <= 6'h00;
        end else if (sclkRise) begin
            bitCount <= bitCount + 6'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cmdShift <= 8'h00;
        end else if (sclkRise) begin
            cmdShift <= cmdByte;
        end
    end

    // Outgoing shifter: loaded at the command's last edge, advanced on falling edges
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            shifter      <= 32'h00000000;
            xferLen      <= asf_pkg::LEN_OTHER;
            readIsStatus <= 1'b0;
        end else if (cmdRead) begin
            shifter      <= loadWord;
            xferLen      <= loadLen;
            readIsStatus <= addrStat;
        end else if (cmdWrite) begin
            xferLen      <= asf_pkg::LEN_OTHER;
            readIsStatus <= 1'b0;
        end else if (sclkFall && state == asf_pkg::ASF_READ) begin
            shifter <= {shifter[30:0], 1'b0};
        end
    end

    // Written bytes are passed out; status ignores them
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            targetRegisterSelect <= 6'h00;
            writeByteValid       <= 1'b0;
            writeByte            <= 8'h00;
        end else begin
            if (cmdValid) begin
                targetRegisterSelect <= cmdAddr;
            end
            writeByteValid <= writeEnd && (targetRegisterSelect != asf_pkg::ADDR_STATUS); // see R15
            if (writeEnd) begin
                writeByte <= cmdByte;
            end
        end
    end

    // Ready flag: new result outranks a simultaneous data read
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdyFlag <= asf_pkg::STATUS_RESET[asf_pkg::RDY_BIT]; // see R1
        end else if (rdyClear) begin
            rdyFlag <= 1'b0; // see R4 see R5
        end else if (dataRead) begin
            rdyFlag <= 1'b1; // see R6
        end
    end

    // Range flag, tag and data move only with a conversion result
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rangeErr <= asf_pkg::STATUS_RESET[asf_pkg::RANGE_ERR_BIT];
            chanTag  <= '0;
            dataReg  <= '0;
        end else if (convWrite) begin
            rangeErr <= overRange || underRange; // see R7 see R8
            chanTag  <= resultChannel; // see R13
            dataReg  <= clampedResult; // see R7
        end
    end

    // Checksum flag: a failing write in the clearing cycle still sets it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            crcErr <= asf_pkg::STATUS_RESET[asf_pkg::CRC_ERR_BIT];
        end else if (writeCrcFail) begin
            crcErr <= 1'b1; // see R9
        end else if (statusRdEnd) begin
            crcErr <= 1'b0; // see R10
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            integErr <= asf_pkg::STATUS_RESET[asf_pkg::INTEG_ERR_BIT];
        end else if (!integrityEnable) begin
            integErr <= 1'b0; // see R12
        end else if (integrityMismatch) begin
            integErr <= 1'b1; // see R11
        end
    end

    // Pin drive from flops; enable follows synchronised select
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            doutRdy   <= 1'b1;
            doutRdyOe <= 1'b0;
        end else begin
            doutRdyOe <= !csSync;
            if (next_state == asf_pkg::ASF_READ) begin
                doutRdy <= cmdRead ? loadWord[31]
                         : (sclkFall ? shifter[31] : doutRdy);
            end else begin
                doutRdy <= rdyClear ? 1'b0 : (dataRead ? 1'b1 : rdyFlag); // see R3
            end
        end
    end

    assign dataValue = dataReg;
endmodule
`default_nettype wire

//--- verification/asf_status_flags_sva.sv
// Assertion checker for the conversion status flag block
`timescale 1ns/1ps
`default_nettype none
module asf_status_flags_chk #(
    parameter int RESULT_WIDTH  = asf_pkg::RESULT_WIDTH,
    parameter int CHANNEL_WIDTH = asf_pkg::CHANNEL_WIDTH
) (
    input wire logic                     sys_clk,
    input wire logic                     rstn,
    input wire logic                     resultWrite,
    input wire logic [RESULT_WIDTH-1:0]  resultValue,
    input wire logic [CHANNEL_WIDTH-1:0] resultChannel,
    input wire logic                     overRange,
    input wire logic                     underRange,
    input wire logic                     calibMode,
    input wire logic                     calibWrite,
    input wire logic                     integrityEnable,
    input wire logic                     integrityMismatch,
    input wire logic                     writeCrcFail,
    input wire logic [7:0]               conversionStatus,
    input wire logic [RESULT_WIDTH-1:0]  dataValue
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Calibration mode results move only the ready flag
    wire logic store = resultWrite && !calibMode;
    chk_ready_clear: assert property (store |=> !conversionStatus[7]) else $error("ready kept");
    chk_calib_ready: assert property (calibMode && calibWrite |=> !conversionStatus[7]) else $error("calib");
    chk_chan_tag: assert property (store |=> conversionStatus[3:0] == $past(resultChannel)) else $error("chan");
    chk_range_flag: assert property (store |=> conversionStatus[6] == $past(overRange || underRange))
        else $error("range flag");
    chk_range_hold: assert property (!resultWrite |=> $stable(conversionStatus[6])) else $error("range moved");
    chk_clamp_value: assert property (store |=> dataValue == ($past(overRange) ? asf_pkg::RESULT_OVER :
        $past(underRange) ? asf_pkg::RESULT_UNDER : $past(resultValue))) else $error("clamp");
    chk_crc_set: assert property (writeCrcFail |=> conversionStatus[5]) else $error("crc flag");
    chk_integ_set: assert property (integrityEnable && integrityMismatch |=> conversionStatus[4]) else $error("integ");
    chk_integ_clear: assert property (!integrityEnable |=> !conversionStatus[4]) else $error("integ kept");
    cov_over: cover property (store && overRange);
    cov_crc: cover property (writeCrcFail);
    cov_calib: cover property (calibMode && calibWrite);
endmodule
bind asf_status_flags asf_status_flags_chk #(.RESULT_WIDTH(RESULT_WIDTH), .CHANNEL_WIDTH(CHANNEL_WIDTH)) chk (.*);
`default_nettype wire

//--- verification/asf_host_model.sv
// Host serial master model, clock idles high between frames
`timescale 1ns/1ps
`default_nettype none
module asf_host_model (
    output logic      csN,
    output logic      sclk,
    output logic      din,
    input  wire logic pin
);
    initial begin
        csN = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
    end
    // Command byte leads each frame, MSB first
    task automatic xfer(input logic [7:0] cmd, input int n, input logic [31:0] tx, output logic [31:0] rx);
        logic [39:0] sh;
        sh = {cmd, tx};
        rx = '0;
        csN = 1'b0;
        #32;
        for (int i = 0; i < n + 8; i++) begin
            sclk = 1'b0;
            din = sh[39];
            sh = sh << 1;
            // Taken at the rising edge; ready replaces the last bit soon after
            #32 if (i >= 8) rx = {rx[30:0], pin};
            sclk = 1'b1;
            #32;
        end
        din = ~din;
        csN = 1'b1;
        #64;
    endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the conversion status flag block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        sys_clk, rstn, csN, sclk, din, doutRdy, doutRdyOe, resultWrite, overRange, underRange;
    logic        calibMode, calibWrite, appendStatus, integrityEnable, integrityMismatch, writeCrcFail;
    logic        writeByteValid;
    logic [23:0] resultValue, dataValue;
    logic [7:0]  conversionStatus, writeByte;
    logic [5:0]  targetRegisterSelect;
    logic [3:0]  resultChannel;
    logic [31:0] rx;
    int          err_total, cmp_count;
    // Floating pin when undriven, so a stale bit never passes as read data
    wire logic   pinLevel = doutRdyOe ? doutRdy : 1'bz;
    asf_status_flags dut (.*);
    asf_host_model host (.csN(csN), .sclk(sclk), .din(din), .pin(pinLevel));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic result(input logic [23:0] v, input logic [3:0] ch, input logic [1:0] ou);
        {resultValue, resultChannel, overRange, underRange} = {v, ch, ou};
        resultWrite = 1'b1;
        tick(1);
        resultWrite = 1'b0;
        tick(1);
    endtask
    task automatic t_status();
        check(conversionStatus, 8'h80);
        check(doutRdy, 1'b1);
        result(24'h123456, 4'hF, 2'b00);
        check(conversionStatus, 8'h0F);
        host.xfer(8'h00, 8, 32'hFF000000, rx);
        host.xfer(8'h40, 8, 32'h0, rx);
        check(rx, 32'h0F);
        check(targetRegisterSelect, 6'h00);
        check(doutRdy, 1'b0);
        check(doutRdyOe, 1'b0);
        host.xfer(8'h01, 8, 32'hA5000000, rx);
        check({targetRegisterSelect, writeByte}, {6'h01, 8'hA5});
        check(conversionStatus, 8'h0F);
        result(24'h00ABCD, 4'h3, 2'b10);
        check({conversionStatus, dataValue}, 32'h43FFFFFF);
        result(24'hFFABCD, 4'h3, 2'b01);
        check({conversionStatus, dataValue}, 32'h43000000);
        result(24'h000111, 4'h3, 2'b00);
        check({conversionStatus, dataValue}, 32'h03000111);
        overRange = 1'b1;
        tick(3);
        check(conversionStatus, 8'h03);
        overRange = 1'b0;
        $display("test status done");
    endtask
    task automatic t_read();
        appendStatus = 1'b1;
        result(24'hC0FFEE, 4'h0, 2'b00);
        host.xfer(8'h44, 32, 32'h0, rx);
        check(rx, 32'hC0FFEE00);
        check(conversionStatus, 8'h80);
        appendStatus = 1'b0;
        result(24'h654321, 4'h9, 2'b00);
        host.xfer(8'h44, 24, 32'h0, rx);
        check(rx, 32'h654321);
        check(conversionStatus, 8'h89);
        $display("test read done");
    endtask
    task automatic t_flags();
        calibMode = 1'b1;
        calibWrite = 1'b1;
        tick(1);
        {calibWrite, calibMode, writeCrcFail} = 3'b001;
        tick(1);
        writeCrcFail = 1'b0;
        tick(1);
        check(conversionStatus, 8'h29);
        host.xfer(8'h40, 8, 32'h0, rx);
        check(rx, 32'h29);
        check(conversionStatus, 8'h09);
        integrityMismatch = 1'b1;
        tick(2);
        check(conversionStatus, 8'h09);
        integrityEnable = 1'b1;
        tick(2);
        integrityMismatch = 1'b0;
        tick(4);
        check(conversionStatus, 8'h19);
        integrityEnable = 1'b0;
        tick(2);
        check(conversionStatus, 8'h09);
        $display("test flags done");
    endtask
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        rstn = 1'b0;
        {resultWrite, resultValue, resultChannel, overRange, underRange, calibMode} = '0;
        {calibWrite, appendStatus, integrityEnable, integrityMismatch, writeCrcFail} = '0;
        repeat (12) @(posedge sys_clk);
        #1 rstn = 1'b1;
        tick(6);
        t_status();
        t_read();
        t_flags();
        rstn = 1'b0;
        tick(2);
        rstn = 1'b1;
        tick(6);
        check(conversionStatus, 8'h80);
        final_report();
    end
endmodule
`default_nettype wire
